// ===== rtl/sdc_cache.sv
// system bus data cache: package, control registers and cache engine
//
// Design decisions made here: the address map and the AXI4-Lite register port.
`default_nettype none

package sdc_pkg;
	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam int         AXI_AW     = 8;
	localparam logic [7:0] ADDR_CTRL  = 8'h00;
	localparam logic [7:0] ADDR_FLUSH = 8'h04;
	localparam logic [7:0] ADDR_LINE  = 8'h08;
	localparam logic [7:0] ADDR_SEC   = 8'h0c;
	localparam logic [7:0] ADDR_PAR   = 8'h10;
	localparam logic [7:0] ADDR_PROT  = 8'h14;
	localparam logic [7:0] ADDR_STAT  = 8'h18;
	localparam logic [7:0] ADDR_MASK  = 8'h1c;
	// security groups: control, line config, error registers, attribution
	localparam logic [1:0] GRP_CTRL = 2'h0;
	localparam logic [1:0] GRP_LINE = 2'h1;
	localparam logic [1:0] GRP_ERR  = 2'h2;
	localparam logic [1:0] GRP_SEC  = 2'h3;
	localparam int STAT_PARITY = 0;
	localparam int STAT_FLUSH  = 1;
	// reset values
	localparam logic       ENABLE_RST = 1'b0;
	localparam logic       LINE_RST   = 1'b0;
	localparam logic [2:0] SEC_RST    = 3'h0;
	localparam logic       PAR_RST    = 1'b0;
	localparam logic       PROT_RST   = 1'b0;
	localparam logic [1:0] MASK_RST   = 2'h0;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ----------------------------------------
	// line geometry
	// ----------------------------------------
	localparam int         TAG_W        = 27;
	localparam logic [3:0] LAST_WORD_32 = 4'h7;
	localparam logic [3:0] LAST_WORD_64 = 4'hf;
	localparam logic [31:0] WORD_STEP   = 32'h4;

	typedef enum logic [5:0] {
		ST_IDLE  = 6'b000001,
		ST_HIT   = 6'b000010,
		ST_FILL  = 6'b000100,
		ST_WRITE = 6'b001000,
		ST_PASS  = 6'b010000,
		ST_RESP  = 6'b100000
	} sdc_state_t;
endpackage

module sdc_cache #(
	parameter int SETS = 8
) (
	input  wire logic                     clk,
	input  wire logic                     reset,
	input  wire logic [sdc_pkg::AXI_AW-1:0] awaddr,
	input  wire logic [2:0]               awprot,
	input  wire logic                     awvalid,
	output logic                          awready,
	input  wire logic [31:0]              wdata,
	input  wire logic [3:0]               wstrb,
	input  wire logic                     wvalid,
	output logic                          wready,
	output logic [1:0]                    bresp,
	output logic                          bvalid,
	input  wire logic                     bready,
	input  wire logic [sdc_pkg::AXI_AW-1:0] araddr,
	input  wire logic [2:0]               arprot,
	input  wire logic                     arvalid,
	output logic                          arready,
	output logic [31:0]                   rdata,
	output logic [1:0]                    rresp,
	output logic                          rvalid,
	input  wire logic                     rready,
	input  wire logic                     cpuReq,
	input  wire logic                     cpuWrite,
	input  wire logic                     cpuCacheable,
	input  wire logic [31:0]              cpuAddr,
	input  wire logic [31:0]              cpuWdata,
	output logic                          cpuReady,
	output logic [31:0]                   cpuRdata,
	output logic                          memReq,
	output logic                          memWrite,
	output logic [31:0]                   memAddr,
	output logic [31:0]                   memWdata,
	input  wire logic                     memAck,
	input  wire logic [31:0]              memRdata,
	output logic                          irq,
	output logic                          parityNmi,
	output logic                          parityReset
);
	localparam int IW = $clog2(SETS);
	localparam int RAW = IW + 5;

	// ----------------------------------------
	// decode helpers
	// ----------------------------------------
	function automatic logic [IW-1:0] setOf(logic [31:0] a, logic big);
		return big ? a[6 +: IW] : a[5 +: IW];
	endfunction
	function automatic logic [sdc_pkg::TAG_W-1:0] tagOf(logic [31:0] a,
		logic big);
		return big ? {1'b0, a[31:6]} : a[31:5];
	endfunction
	function automatic logic [3:0] wordOf(logic [31:0] a, logic big);
		return big ? a[5:2] : {1'b0, a[4:2]};
	endfunction
	function automatic logic [1:0] regGroup(logic [7:0] a);
		unique case (a)
			sdc_pkg::ADDR_CTRL, sdc_pkg::ADDR_FLUSH: return sdc_pkg::GRP_CTRL;
			sdc_pkg::ADDR_LINE: return sdc_pkg::GRP_LINE;
			sdc_pkg::ADDR_SEC, sdc_pkg::ADDR_PROT: return sdc_pkg::GRP_SEC;
			default: return sdc_pkg::GRP_ERR;
		endcase
	endfunction
	function automatic logic denied(logic [7:0] a, logic ns, logic [2:0] s);
		logic mapped;
		mapped = (a[1:0] == 2'h0) && (a <= sdc_pkg::ADDR_MASK);
		return !mapped || (ns && ((regGroup(a) == sdc_pkg::GRP_SEC)
			|| s[regGroup(a)]));
	endfunction

	// ----------------------------------------
	// state
	// ----------------------------------------
	// local names for the engine's state codes
	localparam sdc_pkg::sdc_state_t ST_IDLE  = sdc_pkg::ST_IDLE;
	localparam sdc_pkg::sdc_state_t ST_HIT   = sdc_pkg::ST_HIT;
	localparam sdc_pkg::sdc_state_t ST_FILL  = sdc_pkg::ST_FILL;
	localparam sdc_pkg::sdc_state_t ST_WRITE = sdc_pkg::ST_WRITE;
	localparam sdc_pkg::sdc_state_t ST_PASS  = sdc_pkg::ST_PASS;
	localparam sdc_pkg::sdc_state_t ST_RESP  = sdc_pkg::ST_RESP;
	sdc_pkg::sdc_state_t state_q, state_d;
	logic [2*SETS-1:0] valid_q, valid_d;
	logic [SETS-1:0] lru_q, lru_d;
	logic [sdc_pkg::TAG_W-1:0] tag_q [2*SETS];
	logic [sdc_pkg::TAG_W-1:0] tag_d [2*SETS];
	logic [3:0]  wordCnt_q, wordCnt_d;
	logic        way_q, way_d;
	logic        memReq_q, memReq_d, memWrite_q, memWrite_d;
	logic [31:0] memAddr_q, memAddr_d, memWdata_q, memWdata_d;
	logic [31:0] rdata_q, rdata_d;
	logic        nmi_q, nmi_d, rst_q, rst_d;
	logic        enable_q, enable_d, lineBig_q, lineBig_d;
	logic        flushReq_q, flushReq_d, parAct_q, parAct_d;
	logic        prot_q, prot_d;
	logic [2:0]  sec_q, sec_d;
	logic [1:0]  status_q, status_d, mask_q, mask_d;
	logic        awHave_q, awHave_d, awNs_q, awNs_d;
	logic [7:0]  awAddr_q, awAddr_d;
	logic        wHave_q, wHave_d, wStrb0_q, wStrb0_d;
	logic [31:0] wData_q, wData_d;
	logic        bvalid_q, bvalid_d, rvalid_q, rvalid_d;
	logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
	logic [31:0] axiRdata_q, axiRdata_d;

	logic        ramWe;
	logic [RAW-1:0] ramWaddr, ramRaddr;
	logic [32:0] ramWdata, ramRdata;
	logic        parErr, flushGo, doWrite, wrDenied;
	logic [IW-1:0] curSet;
	logic [sdc_pkg::TAG_W-1:0] curTag;
	logic        hit0, hit1, anyHit, lookupOn, victim;

	assign curSet = setOf(cpuAddr, lineBig_q);
	assign curTag = tagOf(cpuAddr, lineBig_q);
	assign hit0 = valid_q[{1'b0, curSet}] && tag_q[{1'b0, curSet}] == curTag;
	assign hit1 = valid_q[{1'b1, curSet}] && tag_q[{1'b1, curSet}] == curTag;
	assign anyHit = hit0 || hit1;
	assign lookupOn = enable_q && cpuCacheable;
	assign victim = !valid_q[{1'b0, curSet}] ? 1'b0 :
		!valid_q[{1'b1, curSet}] ? 1'b1 : lru_q[curSet];

	sdc_data_ram #(.WIDTH(33), .DEPTH(2*SETS*16), .AW(RAW)) u_ram (
		.clk    (clk),
		.wrEn   (ramWe),
		.wrAddr (ramWaddr),
		.wrData (ramWdata),
		.rdAddr (ramRaddr),
		.rdData (ramRdata)
	);

	// ----------------------------------------
	// cache engine
	// ----------------------------------------
	always_comb begin
		state_d = state_q;
		valid_d = valid_q;
		lru_d = lru_q;
		tag_d = tag_q;
		wordCnt_d = wordCnt_q;
		way_d = way_q;
		memReq_d = memReq_q;
		memWrite_d = memWrite_q;
		memAddr_d = memAddr_q;
		memWdata_d = memWdata_q;
		rdata_d = rdata_q;
		ramWe = 1'b0;
		ramWaddr = {hit1, curSet, wordOf(cpuAddr, lineBig_q)};
		ramWdata = {^cpuWdata, cpuWdata};
		ramRaddr = {hit1, curSet, wordOf(cpuAddr, lineBig_q)};
		parErr = 1'b0;
		flushGo = 1'b0;
		cpuReady = 1'b0;
		unique case (state_q)
			ST_IDLE: begin
				if (flushReq_q) begin
					valid_d = '0;
					flushGo = 1'b1;
				end else if (cpuReq && cpuWrite) begin
					memReq_d = 1'b1;
					memWrite_d = 1'b1;
					memAddr_d = cpuAddr;
					memWdata_d = cpuWdata;
					state_d = ST_WRITE;
				end else if (cpuReq && lookupOn && anyHit) begin
					way_d = hit1;
					lru_d[curSet] = !hit1;
					state_d = ST_HIT;
				end else if (cpuReq && lookupOn) begin
					way_d = victim;
					valid_d[{victim, curSet}] = 1'b0;
					wordCnt_d = '0;
					memReq_d = 1'b1;
					memWrite_d = 1'b0;
					memAddr_d = lineBig_q ? {cpuAddr[31:6], 6'h0} :
						{cpuAddr[31:5], 5'h0};
					state_d = ST_FILL;
				end else if (cpuReq) begin
					memReq_d = 1'b1;
					memWrite_d = 1'b0;
					memAddr_d = cpuAddr;
					state_d = ST_PASS;
				end
			end
			ST_HIT: begin
				cpuReady = 1'b1;
				// stored parity is even over 33 bits
				if (^ramRdata) begin
					parErr = 1'b1;
					valid_d[{way_q, curSet}] = 1'b0;
				end
				state_d = ST_IDLE;
			end
			ST_FILL: begin
				if (memAck) begin
					ramWe = 1'b1;
					ramWaddr = {way_q, curSet, wordCnt_q};
					ramWdata = {^memRdata, memRdata};
					memAddr_d = memAddr_q + sdc_pkg::WORD_STEP;
					wordCnt_d = wordCnt_q + 4'h1;
					if (wordCnt_q == (lineBig_q ? sdc_pkg::LAST_WORD_64 :
						sdc_pkg::LAST_WORD_32)) begin
						// idle retries the request and now hits
						memReq_d = 1'b0;
						valid_d[{way_q, curSet}] = 1'b1;
						tag_d[{way_q, curSet}] = curTag;
						lru_d[curSet] = !way_q;
						state_d = ST_IDLE;
					end
				end
			end
			ST_WRITE: begin
				if (memAck) begin
					cpuReady = 1'b1;
					memReq_d = 1'b0;
					memWrite_d = 1'b0;
					// only a hit touches the array
					ramWe = lookupOn && anyHit;
					state_d = ST_IDLE;
				end
			end
			ST_PASS: begin
				if (memAck) begin
					memReq_d = 1'b0;
					rdata_d = memRdata;
					state_d = ST_RESP;
				end
			end
			ST_RESP: begin
				cpuReady = 1'b1;
				state_d = ST_IDLE;
			end
		endcase
		nmi_d = parErr && !parAct_q;
		rst_d = parErr && parAct_q;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state_q <= ST_IDLE;
			valid_q <= '0;
			lru_q <= '0;
			wordCnt_q <= '0;
			way_q <= 1'b0;
			memReq_q <= 1'b0;
			memWrite_q <= 1'b0;
			memAddr_q <= '0;
			memWdata_q <= '0;
			rdata_q <= '0;
			nmi_q <= 1'b0;
			rst_q <= 1'b0;
		end else begin
			state_q <= state_d;
			valid_q <= valid_d;
			lru_q <= lru_d;
			wordCnt_q <= wordCnt_d;
			way_q <= way_d;
			memReq_q <= memReq_d;
			memWrite_q <= memWrite_d;
			memAddr_q <= memAddr_d;
			memWdata_q <= memWdata_d;
			rdata_q <= rdata_d;
			nmi_q <= nmi_d;
			rst_q <= rst_d;
		end
	end

	// tags need no reset: valid bits guard them
	always_ff @(posedge clk) begin
		tag_q <= tag_d;
	end

	assign memReq = memReq_q;
	assign memWrite = memWrite_q;
	assign memAddr = memAddr_q;
	assign memWdata = memWdata_q;
	assign cpuRdata = (state_q == ST_HIT) ? ramRdata[31:0] : rdata_q;
	assign parityNmi = nmi_q;
	assign parityReset = rst_q;

	// ----------------------------------------
	// axi4-lite register slave
	// ----------------------------------------
	assign awready = !awHave_q && !bvalid_q;
	assign wready = !wHave_q && !bvalid_q;
	assign arready = !rvalid_q;
	assign doWrite = awHave_q && wHave_q;
	assign wrDenied = denied(awAddr_q, awNs_q, sec_q);

	always_comb begin
		awHave_d = awHave_q;
		awAddr_d = awAddr_q;
		awNs_d = awNs_q;
		wHave_d = wHave_q;
		wData_d = wData_q;
		wStrb0_d = wStrb0_q;
		bvalid_d = bvalid_q && !bready;
		bresp_d = bresp_q;
		rvalid_d = rvalid_q && !rready;
		rresp_d = rresp_q;
		axiRdata_d = axiRdata_q;
		enable_d = enable_q;
		lineBig_d = lineBig_q;
		sec_d = sec_q;
		parAct_d = parAct_q;
		prot_d = prot_q;
		mask_d = mask_q;
		status_d = status_q;
		flushReq_d = flushReq_q && !flushGo;
		if (awvalid && awready) begin
			awHave_d = 1'b1;
			awAddr_d = awaddr;
			awNs_d = awprot[1];
		end
		if (wvalid && wready) begin
			wHave_d = 1'b1;
			wData_d = wdata;
			wStrb0_d = wstrb[0];
		end
		if (doWrite) begin
			awHave_d = 1'b0;
			wHave_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = wrDenied ? sdc_pkg::RESP_SLVERR : sdc_pkg::RESP_OKAY;
			if (!wrDenied && wStrb0_q) begin
				unique case (awAddr_q)
					sdc_pkg::ADDR_CTRL: enable_d = wData_q[0];
					sdc_pkg::ADDR_FLUSH: flushReq_d = flushReq_d || wData_q[0];
					sdc_pkg::ADDR_LINE: begin
						lineBig_d = wData_q[0];
						flushReq_d = flushReq_d || (wData_q[0] != lineBig_q);
					end
					sdc_pkg::ADDR_SEC: sec_d = prot_q ? wData_q[2:0] : sec_q;
					sdc_pkg::ADDR_PAR: parAct_d = wData_q[0];
					sdc_pkg::ADDR_PROT: prot_d = wData_q[0];
					sdc_pkg::ADDR_STAT: status_d = status_q & ~wData_q[1:0];
					sdc_pkg::ADDR_MASK: mask_d = wData_q[1:0];
					default: ;
				endcase
			end
		end
		// events after the clear so a same-cycle set wins
		status_d[sdc_pkg::STAT_PARITY] =
			status_d[sdc_pkg::STAT_PARITY] || parErr;
		status_d[sdc_pkg::STAT_FLUSH] =
			status_d[sdc_pkg::STAT_FLUSH] || flushGo;
		if (arvalid && arready) begin
			rvalid_d = 1'b1;
			axiRdata_d = '0;
			rresp_d = sdc_pkg::RESP_OKAY;
			if (denied(araddr, arprot[1], sec_q)) begin
				rresp_d = sdc_pkg::RESP_SLVERR;
			end else begin
				unique case (araddr)
					sdc_pkg::ADDR_CTRL: axiRdata_d[0] = enable_q;
					sdc_pkg::ADDR_LINE: axiRdata_d[0] = lineBig_q;
					sdc_pkg::ADDR_SEC: axiRdata_d[2:0] = sec_q;
					sdc_pkg::ADDR_PAR: axiRdata_d[0] = parAct_q;
					sdc_pkg::ADDR_PROT: axiRdata_d[0] = prot_q;
					sdc_pkg::ADDR_STAT: axiRdata_d[1:0] = status_q;
					sdc_pkg::ADDR_MASK: axiRdata_d[1:0] = mask_q;
					default: ;
				endcase
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			awHave_q <= 1'b0;
			awAddr_q <= '0;
			awNs_q <= 1'b0;
			wHave_q <= 1'b0;
			wData_q <= '0;
			wStrb0_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= sdc_pkg::RESP_OKAY;
			rvalid_q <= 1'b0;
			rresp_q <= sdc_pkg::RESP_OKAY;
			axiRdata_q <= '0;
			enable_q <= sdc_pkg::ENABLE_RST;
			lineBig_q <= sdc_pkg::LINE_RST;
			parAct_q <= sdc_pkg::PAR_RST;
			sec_q <= sdc_pkg::SEC_RST;
			prot_q <= sdc_pkg::PROT_RST;
			mask_q <= sdc_pkg::MASK_RST;
			status_q <= '0;
			flushReq_q <= 1'b0;
		end else begin
			awHave_q <= awHave_d;
			awAddr_q <= awAddr_d;
			awNs_q <= awNs_d;
			wHave_q <= wHave_d;
			wData_q <= wData_d;
			wStrb0_q <= wStrb0_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			rvalid_q <= rvalid_d;
			rresp_q <= rresp_d;
			axiRdata_q <= axiRdata_d;
			enable_q <= enable_d;
			lineBig_q <= lineBig_d;
			parAct_q <= parAct_d;
			sec_q <= sec_d;
			prot_q <= prot_d;
			mask_q <= mask_d;
			status_q <= status_d;
			flushReq_q <= flushReq_d;
		end
	end

	assign bvalid = bvalid_q;
	assign bresp = bresp_q;
	assign rvalid = rvalid_q;
	assign rresp = rresp_q;
	assign rdata = axiRdata_q;
	assign irq = |(status_q & mask_q);

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	hitZeroWait_a: assert property (
		(state_q == ST_IDLE && !flushReq_q && cpuReq && !cpuWrite
			&& lookupOn && anyHit) |=> cpuReady && cpuRdata == ramRdata[31:0])
		else $error("read hit not answered next cycle");
	writeThru_a: assert property (
		(state_q == ST_IDLE && !flushReq_q && cpuReq && cpuWrite)
			|=> memReq && memWrite && memAddr == $past(cpuAddr))
		else $error("cpu write not sent to memory");
	writeNoAlloc_a: assert property (
		(state_q == ST_WRITE) |=> valid_q == $past(valid_q))
		else $error("write changed line validity");
	writeHitUpd_a: assert property (
		(state_q == ST_WRITE && memAck && lookupOn && anyHit) |-> ramWe)
		else $error("write hit did not update array");
	flushAll_a: assert property (
		flushGo |=> valid_q == '0 && status_q[sdc_pkg::STAT_FLUSH])
		else $error("flush left a valid line");
	fillOnRead_a: assert property (
		$rose(state_q == ST_FILL) |-> !$past(cpuWrite) && $past(lookupOn))
		else $error("fill not caused by cacheable read");
	bypassPass_a: assert property (
		(state_q == ST_IDLE && !flushReq_q && cpuReq && !cpuWrite
			&& !lookupOn) |=> state_q == ST_PASS ##[1:1000] cpuReady)
		else $error("bypass read not passed through");
	disabledNoFill_a: assert property (
		(state_q == ST_IDLE && !enable_q) |=> state_q != ST_FILL)
		else $error("fill while cache disabled");
	lruVictim_a: assert property (
		(state_q == ST_IDLE && !flushReq_q && cpuReq && !cpuWrite && lookupOn
			&& !anyHit && valid_q[{1'b0, curSet}] && valid_q[{1'b1, curSet}])
			|=> way_q == $past(lru_q[curSet]))
		else $error("victim is not least recently used");
	parityAct_a: assert property (
		parErr |=> parityNmi == !$past(parAct_q)
			&& parityReset == $past(parAct_q))
		else $error("wrong parity error action");
	resetDefault_a: assert property (disable iff (1'b0)
		$past(reset) |-> !parAct_q && !lineBig_q)
		else $error("wrong default after reset");
	secProtect_a: assert property (
		(doWrite && awAddr_q == sdc_pkg::ADDR_SEC && !prot_q)
			|=> $stable(sec_q))
		else $error("attribution written while protected");
	secDeny_a: assert property (
		(doWrite && wrDenied) |=> $stable(enable_q) && $stable(lineBig_q)
			&& bresp == sdc_pkg::RESP_SLVERR)
		else $error("secure-only register written");

endmodule

`default_nettype wire

// ===== rtl/sdc_data_ram.sv
// line data storage with registered read port
`default_nettype none

module sdc_data_ram #(
	parameter int WIDTH = 33,
	parameter int DEPTH = 256,
	parameter int AW    = 8
) (
	input  wire logic             clk,
	input  wire logic             wrEn,
	input  wire logic [AW-1:0]    wrAddr,
	input  wire logic [WIDTH-1:0] wrData,
	input  wire logic [AW-1:0]    rdAddr,
	output logic      [WIDTH-1:0] rdData
);

	logic [WIDTH-1:0] mem [DEPTH];

	// no reset on the array: contents are meaningless until a line is valid
	always_ff @(posedge clk) begin
		if (wrEn) begin
			mem[wrAddr] <= wrData;
		end
		rdData <= mem[rdAddr];
	end

endmodule

`default_nettype wire

// ===== verification/sdc_mem_model.sv
// on-chip sram model answering the cache's memory port
`default_nettype none

module sdc_mem_model (
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic [1:0]  dly,
	input  wire logic        memReq,
	input  wire logic        memWrite,
	input  wire logic [31:0] memAddr,
	input  wire logic [31:0] memWdata,
	output logic             memAck,
	output logic [31:0]      memRdata
);
	timeunit 1ns;
	timeprecision 100ps;

	logic [31:0] mem [0:1023];
	int          cnt;

	initial begin
		for (int i = 0; i < 1024; i++)
			mem[i] = 32'h5a5a0000 + 32'(i);
	end

	// bus released between words: data toggles so no stale value passes
	always @(posedge clk) begin
		memAck <= 1'b0;
		memRdata <= ~memRdata;
		if (reset)
			cnt <= 0;
		else if (memReq && !memAck) begin
			if (cnt >= int'(dly)) begin
				cnt <= 0;
				memAck <= 1'b1;
				if (memWrite)
					mem[memAddr[11:2]] <= memWdata;
				else
					memRdata <= mem[memAddr[11:2]];
			end else
				cnt <= cnt + 1;
		end
	end
endmodule

`default_nettype wire

// ===== verification/test_system_bus_data_cache.sv
// self-checking bench for the system bus data cache
`default_nettype none

`define CHK(g, e) begin checks++; if ((g) !== (e)) begin errorCnt++; \
	$display("MISMATCH %0t got %0h exp %0h", $time, g, e); end end

module test_system_bus_data_cache;
	timeunit 1ns;
	timeprecision 100ps;

	localparam logic [1:0] OK  = sdc_pkg::RESP_OKAY;
	localparam logic [1:0] ERR = sdc_pkg::RESP_SLVERR;

	logic clk, reset, awvalid, wvalid, bready, arvalid, rready, cpuReq;
	logic cpuWrite, cpuCacheable, awready, wready, bvalid, arready, rvalid;
	logic cpuReady, memReq, memWrite, memAck, irq, parityNmi, parityReset;
	logic [7:0]  awaddr, araddr;
	logic [2:0]  awprot, arprot;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, dly;
	logic [31:0] wdata, rdata, cpuAddr, cpuWdata, cpuRdata;
	logic [31:0] memAddr, memWdata, memRdata, rnd;
	logic [31:0] gold [0:1023];
	int          tg [8][2];
	int          lru [8];
	int          seqA [5] = '{0, 'h100, 'h400, 'h100, 0};
	int          en, l64, rds, wrs, errorCnt, checks;

	sdc_cache #(.SETS(8)) DUT (.*);
	sdc_mem_model mem (.*);

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	always @(posedge clk) begin
		if (memAck && memWrite)
			wrs++;
		if (memAck && !memWrite)
			rds++;
	end

	initial begin
		repeat (20000) @(posedge clk);
		errorCnt++;
		completeRun();
	end

	// ----------------------------------------
	// model and bus tasks
	// ----------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction

	function automatic void inval();
		foreach (tg[i, j])
			tg[i][j] = -1;
	endfunction

	task automatic completeRun();
		if (errorCnt == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic wreg(input logic [7:0] a, input logic [2:0] p,
			input logic [31:0] d, input logic [1:0] er);
		@(posedge clk);
		awaddr <= a;
		awprot <= p;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
		`CHK(bresp, er)
	endtask

	task automatic rreg(input logic [7:0] a, input logic [2:0] p,
			input logic [31:0] ed, input logic [1:0] er);
		@(posedge clk);
		araddr <= a;
		arprot <= p;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arready)
				arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rready <= 1'b0;
		`CHK(rdata, ed)
		`CHK(rresp, er)
	endtask

	// writes never allocate; only cacheable enabled read misses fill
	task automatic cpu(input bit wr, input bit ca, input int a);
		int rd, wn, n, lb, s, t, w, er;
		rd = rds;
		wn = wrs;
		lb = l64 ? 64 : 32;
		s = (a / lb) % 8;
		t = a / (lb * 8);
		w = tg[s][0] == t ? 0 : tg[s][1] == t ? 1 : -1;
		er = 0;
		rnd = lfsr(rnd);
		if (!wr && !(en && ca))
			er = 1;
		else if (!wr && w < 0) begin
			er = lb / 4;
			w = tg[s][0] < 0 ? 0 : tg[s][1] < 0 ? 1 : lru[s];
			tg[s][w] = t;
		end
		@(posedge clk);
		cpuReq <= 1'b1;
		cpuWrite <= wr;
		cpuCacheable <= ca;
		cpuAddr <= a;
		cpuWdata <= rnd;
		dly <= rnd[1:0];
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (cpuReady !== 1'b1 && n < 300);
		if (wr)
			gold[a / 4] = rnd;
		else
			`CHK(cpuRdata, gold[a / 4])
		@(posedge clk);
		cpuReq <= 1'b0;
		@(negedge clk);
		if (!wr && en && ca)
			lru[s] = 1 - w;
		`CHK(rds - rd, er)
		`CHK(wrs - wn, int'(wr))
		if (!wr && er == 0)
			`CHK(n, 2)
		`CHK({parityNmi, parityReset}, 2'b00)
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		{awvalid, wvalid, bready, arvalid, rready, cpuReq} = 6'h0;
		{cpuWrite, cpuCacheable, awaddr, araddr, awprot, arprot} = 24'h0;
		{wdata, cpuAddr, cpuWdata, dly} = 98'h0;
		wstrb = 4'hf;
		rnd = 32'h2833;
		reset = 1'b1;
		inval();
		for (int i = 0; i < 1024; i++)
			gold[i] = 32'h5a5a0000 + 32'(i);
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		for (int i = 0; i < 8; i++)
			rreg(8'(4 * i), 3'h0, 32'h0, OK);
		rreg(8'h20, 3'h0, 32'h0, ERR);
		wreg(sdc_pkg::ADDR_SEC, 3'h0, 32'h7, OK);
		rreg(sdc_pkg::ADDR_SEC, 3'h0, 32'h0, OK);
		wreg(sdc_pkg::ADDR_PROT, 3'h0, 32'h1, OK);
		wreg(sdc_pkg::ADDR_SEC, 3'h0, 32'h1, OK);
		rreg(sdc_pkg::ADDR_SEC, 3'h0, 32'h1, OK);
		wreg(sdc_pkg::ADDR_CTRL, 3'h2, 32'h1, ERR);
		rreg(sdc_pkg::ADDR_CTRL, 3'h0, 32'h0, OK);
		wreg(sdc_pkg::ADDR_SEC, 3'h2, 32'h0, ERR);
		wreg(sdc_pkg::ADDR_SEC, 3'h0, 32'h0, OK);
		wreg(sdc_pkg::ADDR_PAR, 3'h2, 32'h1, OK);
		rreg(sdc_pkg::ADDR_PAR, 3'h0, 32'h1, OK);
		wreg(sdc_pkg::ADDR_CTRL, 3'h2, 32'h1, OK);
		en = 1;
		cpu(0, 1, 'h100);
		cpu(0, 1, 'h104);
		cpu(1, 1, 'h108);
		cpu(0, 1, 'h108);
		cpu(1, 1, 'h400);
		cpu(0, 1, 'h400);
		cpu(0, 0, 'h100);
		wreg(sdc_pkg::ADDR_FLUSH, 3'h0, 32'h0, OK);
		cpu(0, 1, 'h100);
		wreg(sdc_pkg::ADDR_FLUSH, 3'h0, 32'h1, OK);
		inval();
		cpu(0, 1, 'h400);
		cpu(0, 1, 'h100);
		rreg(sdc_pkg::ADDR_STAT, 3'h0, 32'h2, OK);
		wreg(sdc_pkg::ADDR_MASK, 3'h0, 32'h2, OK);
		@(negedge clk);
		`CHK(irq, 1'b1)
		wreg(sdc_pkg::ADDR_STAT, 3'h0, 32'h2, OK);
		@(negedge clk);
		`CHK(irq, 1'b0)
		foreach (seqA[i])
			cpu(0, 1, seqA[i]);
		repeat (16) begin
			rnd = lfsr(rnd);
			cpu(0, rnd[12], int'(rnd[11:2]) * 4);
		end
		wreg(sdc_pkg::ADDR_CTRL, 3'h0, 32'h0, OK);
		en = 0;
		cpu(0, 1, 'h100);
		wreg(sdc_pkg::ADDR_LINE, 3'h0, 32'h1, OK);
		inval();
		l64 = 1;
		wreg(sdc_pkg::ADDR_CTRL, 3'h0, 32'h1, OK);
		en = 1;
		cpu(0, 1, 'h800);
		cpu(0, 1, 'h83c);
		rreg(sdc_pkg::ADDR_LINE, 3'h0, 32'h1, OK);
		completeRun();
	end
endmodule

`default_nettype wire
